// File: hdl/spl_params.svh
// Purpose: Offsets, codes and reset values of the phy error log block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH

// Register byte offsets
`define SPL_OFF_INVDW      8'h00
`define SPL_OFF_DISP       8'h04
`define SPL_OFF_SYNCLOSS   8'h08
`define SPL_OFF_RSTPROB    8'h0C
`define SPL_OFF_LINKSTAT   8'h10
`define SPL_OFF_ATTROLE    8'h14
`define SPL_OFF_ATTADDR_LO 8'h18
`define SPL_OFF_ATTADDR_HI 8'h1C
`define SPL_OFF_OWNADDR_LO 8'h20
`define SPL_OFF_OWNADDR_HI 8'h24
`define SPL_OFF_PHYCFG     8'h28
`define SPL_OFF_DESCHDR    8'h3C
`define SPL_OFF_DESC_BASE  8'h40
`define SPL_OFF_DESC_LAST  8'h6C

// Link status field positions
`define SPL_LS_RATE_LSB    0
`define SPL_LS_REASON_LSB  4
`define SPL_LS_ATTRSN_LSB  8
`define SPL_LS_DEVTYPE_LSB 12
`define SPL_LS_GEN_LSB     16

// Phy config field positions and reset value
`define SPL_CFG_ENABLE_BIT  0
`define SPL_CFG_VIRTUAL_BIT 1
`define SPL_CFG_RESET       32'h0000_0001

// Negotiated rate codes
`define SPL_RATE_1G5       4'h8
`define SPL_RATE_3G0       4'h9
`define SPL_RATE_6G0       4'hA
`define SPL_RATE_12G0      4'hB
`define SPL_RATE_DISABLED  4'h1

// Generation code values
`define SPL_GEN_RESET      8'h00
`define SPL_GEN_MAX        8'hFF
`define SPL_GEN_WRAP       8'h01

// Event descriptor list constants
`define SPL_DESC_LEN       8'h0C
`define SPL_DESC_COUNT     8'h04
`define SPL_SRC_INVDW      8'h01
`define SPL_SRC_DISP       8'h02
`define SPL_SRC_SYNCLOSS   8'h03
`define SPL_SRC_RSTPROB    8'h04
`define SPL_PEAK_THRESH    32'h0000_0000

`endif

// File: hdl/spl_pkg.sv
// Purpose: Types shared by the phy error log block
// Assumes: Constants live in spl_params.svh
// Notes:   Carriers for phy events and identify frames
package spl_pkg;

    // Link rate negotiated at link reset
    typedef enum logic [1:0] {
        SPL_R1G5  = 2'h0,
        SPL_R3G0  = 2'h1,
        SPL_R6G0  = 2'h2,
        SPL_R12G0 = 2'h3
    } spl_rate_t;

    // Per-cycle receive events from the phy
    typedef struct packed {
        logic invalidDword;
        logic dispErr;
        logic syncLost;
        logic resetProblem;
        logic resetInProg;
        logic dwordSync;
    } spl_evt_t;

    // Received identify frame, valid with frameValid
    typedef struct packed {
        logic        frameValid;
        logic [2:0]  devType;
        logic [3:0]  reason;
        logic [2:0]  initBits;
        logic [2:0]  tgtBits;
        logic [63:0] sasAddr;
        logic [7:0]  phyId;
    } spl_rxid_t;

    // Transmitted identify frame, valid with frameValid
    typedef struct packed {
        logic        frameValid;
        logic [3:0]  reason;
        logic [63:0] sasAddr;
    } spl_txid_t;

    // Link reset outcome
    typedef struct packed {
        logic      linkUp;
        spl_rate_t rate;
    } spl_link_t;

endpackage

// File: hdl/spl_sat_counter.sv
// Purpose: Saturating event counter
// Assumes: One event per clock at most
// Notes:   Cleared only by reset
`timescale 1ns/1ps
module spl_sat_counter #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Event and count
    input  wire logic             inc,
    output logic      [WIDTH-1:0] count
);

    // Counter stops at all ones
    wire atMax = &count;

    // Count qualified events
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (inc && !atMax) begin
            count <= count + WIDTH'(1);
        end
    end

    // Once at all ones the count never moves again
    a_sat_holds: assert property (
        @(posedge clk) disable iff (!rst_b) atMax |=> atMax)
        else $error("Counter left saturation");

endmodule

// File: hdl/spl_phy_log.sv
// Purpose: Phy error counters, link status and event list over APB
// Assumes: Phy event inputs come from logic on clk
// Notes:   One wait state on every APB access
//
// What this block does
// - Count invalid dwords outside phy reset
// - Count disparity errors while dword synchronised
// - Disparity count frozen while sync lost
// - Count sync losses that restart link reset
// - Count reset failures from speed-match sync
// - All error counters saturate at maximum
// - Report negotiated rate codes 8h to Bh
// - Generation code steps on settings change
// - Generation wraps FFh to 01h, never 00h
// - Attached reason from last received frame
// - SATA attached: reason cleared after D2H FIS
// - Virtual phy reports attached reason 0h
// - Local reason from last transmitted frame
// - Latch received identify fields, own address
// - Descriptors 0Ch bytes, exactly 04h of them
// - Sources 01h-04h, counts since power on
// - Peak threshold fields read all zeros
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "spl_params.svh"
module spl_phy_log
    import spl_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Phy side
    input  wire spl_evt_t    phyEvt,
    input  wire spl_rxid_t   rxId,
    input  wire spl_txid_t   txId,
    input  wire spl_link_t   linkRes,
    input  wire logic        sataAttached,
    input  wire logic        d2hFisRx,
    // Command layer
    input  wire logic        settingsChanged
);

    // Counter values and captured state
    logic [CNT_W-1:0] invCnt;
    logic [CNT_W-1:0] dispCnt;
    logic [CNT_W-1:0] syncCnt;
    logic [CNT_W-1:0] rstCnt;
    logic [31:0]      phyCfg;
    logic [7:0]       genCode;
    logic [3:0]       rateCode;
    logic [3:0]       localReason;
    logic [3:0]       attReason;
    logic [2:0]       attDevType;
    logic [2:0]       attInit;
    logic [2:0]       attTgt;
    logic [63:0]      attAddr;
    logic [7:0]       attPhyId;
    logic [63:0]      ownAddr;

    // Event qualification
    wire incInv  = phyEvt.invalidDword && !phyEvt.resetInProg;
    wire incDisp = phyEvt.dispErr && phyEvt.dwordSync;
    wire incSync = phyEvt.syncLost;
    wire incRst  = phyEvt.resetProblem;

    // Saturating counters, one per event source
    spl_sat_counter #(.WIDTH(CNT_W)) uInv (
        .clk   (clk),
        .rst_b (rst_b),
        .inc   (incInv),
        .count (invCnt)
    );
    spl_sat_counter #(.WIDTH(CNT_W)) uDisp (
        .clk   (clk),
        .rst_b (rst_b),
        .inc   (incDisp),
        .count (dispCnt)
    );
    spl_sat_counter #(.WIDTH(CNT_W)) uSync (
        .clk   (clk),
        .rst_b (rst_b),
        .inc   (incSync),
        .count (syncCnt)
    );
    spl_sat_counter #(.WIDTH(CNT_W)) uRst (
        .clk   (clk),
        .rst_b (rst_b),
        .inc   (incRst),
        .count (rstCnt)
    );

    // Widen a counter into a bus word
    function automatic logic [31:0] cntWord(input logic [CNT_W-1:0] c);
        logic [31:0] w;
        w = '0;
        w[CNT_W-1:0] = c;
        return w;
    endfunction

    // Merge write data under byte strobes
    function automatic logic [31:0] strbMerge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  sb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Map a negotiated rate onto its reported code
    function automatic logic [3:0] rateToCode(input spl_rate_t r);
        case (r)
            SPL_R1G5:  return `SPL_RATE_1G5;
            SPL_R3G0:  return `SPL_RATE_3G0;
            SPL_R6G0:  return `SPL_RATE_6G0;
            SPL_R12G0: return `SPL_RATE_12G0;
            default:   return `SPL_RATE_1G5;
        endcase
    endfunction

    // Config bits that steer the block
    wire phyEnable  = phyCfg[`SPL_CFG_ENABLE_BIT];
    wire virtualPhy = phyCfg[`SPL_CFG_VIRTUAL_BIT];

    // APB phase decode
    wire apbAccess = psel && penable;
    wire apbFirst  = apbAccess && !pready;
    wire apbDone   = apbAccess && pready;
    wire cfgHit    = (paddr == `SPL_OFF_PHYCFG);
    wire cfgWrite  = apbDone && pwrite && cfgHit && !pslverr;
    wire [31:0] next_phyCfg = strbMerge(phyCfg, pwdata, pstrb);
    wire cfgChange = cfgWrite && (next_phyCfg != phyCfg);

    // Phy config register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phyCfg <= `SPL_CFG_RESET;
        end else if (cfgWrite) begin
            phyCfg <= next_phyCfg;
        end
    end

    // Generation code, 00h kept for unknown
    wire genBump = cfgChange || settingsChanged;
    wire [7:0] next_genCode = (genCode == `SPL_GEN_MAX) ?
                              `SPL_GEN_WRAP : genCode + 8'h01;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            genCode <= `SPL_GEN_RESET;
        end else if (genBump) begin
            genCode <= next_genCode;
        end
    end

    // Rate code from the last link reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rateCode <= `SPL_RATE_1G5;
        end else if (linkRes.linkUp) begin
            rateCode <= rateToCode(linkRes.rate);
        end
    end
    wire [3:0] rptRate = phyEnable ? rateCode : `SPL_RATE_DISABLED;

    // Local reason and own address from transmitted frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            localReason <= 4'h0;
            ownAddr     <= 64'h0;
        end else if (txId.frameValid) begin
            localReason <= txId.reason;
            ownAddr     <= txId.sasAddr;
        end
    end

    // Received identify fields
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            attDevType <= 3'h0;
            attInit    <= 3'h0;
            attTgt     <= 3'h0;
            attAddr    <= 64'h0;
            attPhyId   <= 8'h0;
        end else if (rxId.frameValid) begin
            attDevType <= rxId.devType;
            attInit    <= rxId.initBits;
            attTgt     <= rxId.tgtBits;
            attAddr    <= rxId.sasAddr;
            attPhyId   <= rxId.phyId;
        end
    end

    // Attached reason, SAS frame or SATA clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            attReason <= 4'h0;
        end else if (sataAttached && d2hFisRx) begin
            attReason <= 4'h0;
        end else if (!sataAttached && rxId.frameValid) begin
            attReason <= rxId.reason;
        end
    end
    wire [3:0] rptAttReason = virtualPhy ? 4'h0 : attReason;

    // Status words
    wire [31:0] linkStat = {8'h00, genCode, 1'b0, attDevType,
                            rptAttReason, localReason, rptRate};
    wire [31:0] attRole  = {16'h0000, attPhyId, 1'b0, attTgt,
                            1'b0, attInit};
    wire [31:0] descHdr  = {16'h0000, `SPL_DESC_LEN, `SPL_DESC_COUNT};

    // Event descriptor word: source, count, threshold
    function automatic logic [31:0] descWord(input logic [3:0] k);
        logic [1:0]       d;
        logic [1:0]       w;
        logic [CNT_W-1:0] c;
        logic [7:0]       s;
        d = 2'(k / 4'd3);
        w = 2'(k % 4'd3);
        case (d)
            2'h0: begin
                c = invCnt;
                s = `SPL_SRC_INVDW;
            end
            2'h1: begin
                c = dispCnt;
                s = `SPL_SRC_DISP;
            end
            2'h2: begin
                c = syncCnt;
                s = `SPL_SRC_SYNCLOSS;
            end
            default: begin
                c = rstCnt;
                s = `SPL_SRC_RSTPROB;
            end
        endcase
        case (w)
            2'h0:    return {24'h000000, s};
            2'h1:    return cntWord(c);
            default: return `SPL_PEAK_THRESH;
        endcase
    endfunction

    // Read decode
    wire       descHit = (paddr >= `SPL_OFF_DESC_BASE) &&
                         (paddr <= `SPL_OFF_DESC_LAST);
    wire [7:0] descOff = paddr - `SPL_OFF_DESC_BASE;
    wire       aligned = (paddr[1:0] == 2'b00);
    wire       roWrite = pwrite && !cfgHit;
    logic [31:0] rdMux;
    logic        rdHit;
    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        case (paddr)
            `SPL_OFF_INVDW:      rdMux = cntWord(invCnt);
            `SPL_OFF_DISP:       rdMux = cntWord(dispCnt);
            `SPL_OFF_SYNCLOSS:   rdMux = cntWord(syncCnt);
            `SPL_OFF_RSTPROB:    rdMux = cntWord(rstCnt);
            `SPL_OFF_LINKSTAT:   rdMux = linkStat;
            `SPL_OFF_ATTROLE:    rdMux = attRole;
            `SPL_OFF_ATTADDR_LO: rdMux = attAddr[31:0];
            `SPL_OFF_ATTADDR_HI: rdMux = attAddr[63:32];
            `SPL_OFF_OWNADDR_LO: rdMux = ownAddr[31:0];
            `SPL_OFF_OWNADDR_HI: rdMux = ownAddr[63:32];
            `SPL_OFF_PHYCFG:     rdMux = phyCfg;
            `SPL_OFF_DESCHDR:    rdMux = descHdr;
            default: begin
                if (descHit && aligned) begin
                    rdMux = descWord(descOff[5:2]);
                end else begin
                    rdHit = 1'b0;
                end
            end
        endcase
    end
    wire badAccess = !rdHit || (roWrite && aligned);

    // APB answer after one wait state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbFirst;
            pslverr <= apbFirst && badAccess;
            if (apbFirst && !pwrite) begin
                prdata <= rdHit ? rdMux : 32'h0000_0000;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    sequence s_apbStart;
        psel && penable && !pready;
    endsequence
    sequence s_apbEnd;
        pready ##1 !pready;
    endsequence

    a_apb_one_wait: assert property (s_apbStart |=> s_apbEnd)
        else $error("APB answer not after one wait state");
    a_inv_excluded: assert property (
        phyEvt.resetInProg |=> $stable(invCnt))
        else $error("Invalid dword counted during reset");
    a_inv_counts: assert property (
        phyEvt.invalidDword && !phyEvt.resetInProg && invCnt != CNT_MAX
        |=> invCnt == $past(invCnt) + 1'b1)
        else $error("Invalid dword not counted");
    a_disp_counts: assert property (
        phyEvt.dispErr && phyEvt.dwordSync && dispCnt != CNT_MAX
        |=> dispCnt == $past(dispCnt) + 1'b1)
        else $error("Disparity error not counted");
    a_disp_frozen: assert property (
        !phyEvt.dwordSync |=> $stable(dispCnt))
        else $error("Disparity count moved without sync");
    a_sync_counts: assert property (
        incSync && syncCnt != CNT_MAX |=> syncCnt == $past(syncCnt) + 1'b1)
        else $error("Sync loss not counted");
    a_rst_counts: assert property (
        incRst && rstCnt != CNT_MAX |=> rstCnt == $past(rstCnt) + 1'b1)
        else $error("Reset problem not counted");
    a_rate_fast: assert property (
        linkRes.linkUp && linkRes.rate == SPL_R12G0 && phyEnable
        && !cfgWrite |=> rptRate == `SPL_RATE_12G0)
        else $error("Rate code wrong for 12G");
    a_gen_step: assert property (
        genBump && genCode != `SPL_GEN_MAX
        |=> genCode == $past(genCode) + 8'h01)
        else $error("Generation code did not step");
    a_gen_wrap: assert property (
        genBump && genCode == `SPL_GEN_MAX |=> genCode == `SPL_GEN_WRAP)
        else $error("Generation code did not wrap to 01h");
    a_sata_clear: assert property (
        sataAttached && d2hFisRx |=> attReason == 4'h0)
        else $error("Attached reason not cleared for SATA");
    a_virt_zero: assert property (
        apbFirst && !pwrite && paddr == `SPL_OFF_LINKSTAT && virtualPhy
        |=> prdata[`SPL_LS_ATTRSN_LSB +: 4] == 4'h0)
        else $error("Virtual phy attached reason not zero");

endmodule

// File: tb/spl_phy_model.sv
// Purpose: Behavioural attached phy feeding the log block
// Assumes: Every pulse lasts one clk cycle
// Notes:   Released identify and link fields show the inverse of their last value
`timescale 1ns/1ps
module spl_phy_model
    import spl_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Phy side
    output spl_evt_t  phyEvt,
    output spl_rxid_t rxId,
    output spl_txid_t txId,
    output spl_link_t linkRes,
    output logic      sataAttached,
    output logic      d2hFisRx
);
    // Quiet lines at time zero
    initial begin
        phyEvt = '0;
        rxId = '0;
        txId = '0;
        linkRes = '0;
        sataAttached = 1'b0;
        d2hFisRx = 1'b0;
    end

    // Event pulses, k picks the source, levels held throughout
    task automatic evt(input int k, input int n, input logic rip,
                       input logic sync);
        logic [3:0] oh;
        oh = 4'h8 >> k;
        repeat (n) begin
            @(posedge clk) phyEvt <= {oh, rip, sync};
            @(posedge clk) phyEvt <= {4'h0, rip, sync};
        end
    endtask

    // Received identify frame
    task automatic sendRx(input logic [2:0] dt, input logic [3:0] rs,
                          input logic [2:0] ib, input logic [2:0] tg,
                          input logic [63:0] ad, input logic [7:0] id);
        @(posedge clk) rxId <= {1'b1, dt, rs, ib, tg, ad, id};
        @(posedge clk) rxId <= ~{1'b1, dt, rs, ib, tg, ad, id};
    endtask

    // Transmitted identify frame
    task automatic sendTx(input logic [3:0] rs, input logic [63:0] ad);
        @(posedge clk) txId <= {1'b1, rs, ad};
        @(posedge clk) txId <= ~{1'b1, rs, ad};
    endtask

    // Link reset outcome
    task automatic link(input spl_rate_t r);
        @(posedge clk) linkRes <= {1'b1, r};
        @(posedge clk) linkRes <= ~{1'b1, r};
    endtask

    // SATA presence and first D2H FIS
    task automatic sata(input logic v);
        @(posedge clk) sataAttached <= v;
    endtask

    task automatic fis();
        @(posedge clk) d2hFisRx <= 1'b1;
        @(posedge clk) d2hFisRx <= 1'b0;
    endtask
endmodule

// File: tb/tb_spl_phy_log.sv
// Purpose: Self-checking bench of the phy error log block
// Assumes: Counters built 3 bits wide to reach saturation
// Notes:   APB master waits on pready with a bounded loop
`timescale 1ns/1ps
module tb_spl_phy_log;
    import spl_pkg::*;
    localparam int          CW  = 3;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    // Bench signals
    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        settingsChanged;
    spl_evt_t    phyEvt;
    spl_rxid_t   rxId;
    spl_txid_t   txId;
    spl_link_t   linkRes;
    logic        sataAttached;
    logic        d2hFisRx;
    int          failures;
    int          nCompared;

    // Block under test and attached phy
    spl_phy_log #(.CNT_W(CW)) spl_phy_log_inst (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phyEvt(phyEvt), .rxId(rxId), .txId(txId),
        .linkRes(linkRes), .sataAttached(sataAttached),
        .d2hFisRx(d2hFisRx), .settingsChanged(settingsChanged));
    spl_phy_model spl_phy_model_inst (
        .clk(clk), .phyEvt(phyEvt), .rxId(rxId), .txId(txId),
        .linkRes(linkRes), .sataAttached(sataAttached),
        .d2hFisRx(d2hFisRx));

    // 200 MHz clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    task automatic results();
        $display("compared %0d, failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        nCompared++;
        if (got !== ex) begin
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
            failures++;
        end
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            $display("[FAIL] pready expected 1 seen 0");
            failures++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input string nm, input logic [7:0] ad,
                         input logic [31:0] m, input logic [31:0] ex);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, ad, 32'h0, rd, er);
        chk(nm, ex, rd & m);
        chk("slverr", 32'h0, {31'h0, er});
    endtask

    task automatic wrChk(input logic [7:0] ad, input logic [31:0] d,
                         input logic ee);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, ad, d, rd, er);
        chk("slverr", {31'h0, ee}, {31'h0, er});
    endtask

    // Values after reset and fixed descriptor fields
    task automatic tReset();
        for (int i = 0; i < 4; i++) begin
            rdChk("count", 8'(4 * i), ALL, 32'h0);
            rdChk("source", 8'(8'h40 + 12 * i), ALL, 32'(i + 1));
            rdChk("thresh", 8'(8'h48 + 12 * i), ALL, 32'h0);
        end
        rdChk("linkstat", 8'h10, 32'h00FF_000F, 32'h8);
        rdChk("phycfg", 8'h28, ALL, 32'h1);
        rdChk("header", 8'h3C, 32'hFFFF, 32'h0C04);
    endtask

    // Qualified counting, freeze, saturation, shared descriptors
    task automatic tCount();
        logic [31:0] ex [4];
        ex = '{32'((1 << CW) - 1), 32'h3, 32'h2, 32'h1};
        spl_phy_model_inst.evt(0, 2, 1'b0, 1'b1);
        spl_phy_model_inst.evt(0, 3, 1'b1, 1'b1);
        rdChk("invdw", 8'h00, ALL, 32'h2);
        spl_phy_model_inst.evt(0, 6, 1'b0, 1'b1);
        rdChk("invdw sat", 8'h00, ALL, ex[0]);
        spl_phy_model_inst.evt(1, 3, 1'b0, 1'b1);
        spl_phy_model_inst.evt(1, 2, 1'b0, 1'b0);
        rdChk("disp", 8'h04, ALL, 32'h3);
        spl_phy_model_inst.evt(2, 2, 1'b0, 1'b1);
        rdChk("syncloss", 8'h08, ALL, 32'h2);
        spl_phy_model_inst.evt(3, 1, 1'b1, 1'b1);
        rdChk("rstprob", 8'h0C, ALL, 32'h1);
        for (int i = 0; i < 4; i++)
            rdChk("event", 8'(8'h44 + 12 * i), ALL, ex[i]);
    endtask

    // Every negotiated rate code
    task automatic tRate();
        for (int i = 0; i < 4; i++) begin
            spl_phy_model_inst.link(spl_rate_t'(i));
            rdChk("rate", 8'h10, 32'hF, 32'(8 + i));
        end
    endtask

    // Identify fields, SATA and virtual reason handling
    task automatic tIdent();
        spl_phy_model_inst.sendTx(4'h3, 64'hA5A5_0000_1111_2222);
        spl_phy_model_inst.sendRx(3'h2, 4'h5, 3'h5, 3'h2,
                                  64'h0123_4567_89AB_CDEF, 8'h07);
        rdChk("reasons", 8'h10, 32'h7FF0, 32'h2530);
        rdChk("role", 8'h14, 32'hFF77, 32'h0725);
        rdChk("att hi", 8'h1C, ALL, 32'h0123_4567);
        rdChk("att lo", 8'h18, ALL, 32'h89AB_CDEF);
        rdChk("own lo", 8'h20, ALL, 32'h1111_2222);
        rdChk("own hi", 8'h24, ALL, 32'hA5A5_0000);
        spl_phy_model_inst.sata(1'b1);
        spl_phy_model_inst.fis();
        rdChk("sata rsn", 8'h10, 32'hF00, 32'h0);
        spl_phy_model_inst.sata(1'b0);
        spl_phy_model_inst.sendRx(3'h1, 4'h6, 3'h0, 3'h1, 64'h0, 8'h01);
        rdChk("att rsn", 8'h10, 32'hF00, 32'h600);
        wrChk(8'h28, 32'h3, 1'b0);
        rdChk("virt rsn", 8'h10, 32'hF00, 32'h0);
        wrChk(8'h28, 32'h0, 1'b0);
        rdChk("off rate", 8'h10, 32'hF, 32'h1);
        wrChk(8'h28, 32'h1, 1'b0);
    endtask

    // Generation steps and wrap past FFh
    task automatic tGen();
        wrChk(8'h28, 32'h1, 1'b0);
        rdChk("gen", 8'h10, 32'hFF_0000, 32'h3_0000);
        repeat (252) begin
            @(posedge clk) settingsChanged <= 1'b1;
            @(posedge clk) settingsChanged <= 1'b0;
        end
        rdChk("gen max", 8'h10, 32'hFF_0000, 32'hFF_0000);
        @(posedge clk) settingsChanged <= 1'b1;
        @(posedge clk) settingsChanged <= 1'b0;
        rdChk("gen wrap", 8'h10, 32'hFF_0000, 32'h1_0000);
    endtask

    // Read-only, unmapped and misaligned accesses
    task automatic tRefuse();
        logic [31:0] rd;
        logic        er;
        wrChk(8'h00, 32'h5, 1'b1);
        rdChk("ro kept", 8'h00, ALL, 32'((1 << CW) - 1));
        apb(1'b0, 8'h80, 32'h0, rd, er);
        chk("unmapped", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b0, 8'h02, 32'h0, rd, er);
        chk("misaligned", 32'h1, {31'h0, er});
    endtask

    // Main sequence
    initial begin
        failures = 0;
        nCompared = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        settingsChanged = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        tReset();
        tCount();
        tRate();
        tIdent();
        tGen();
        tRefuse();
        results();
    end
endmodule
